// ### src/dsbio_pkg.sv
// Constants and types shared by the dual six-bit pin group block.
// Assumes a core that issues one register request per instruction cycle.
// Function
// - Port reads return the pin levels, never the output latches.
// - Any reset sets every direction bit, so all pins become inputs.
// - Group B holds six bits; bits 7 and 6 read as zero.
// - Group C holds six bits; its upper two bits read as zero.
// - Group B bit 3 is input only; its driver never turns on.
// - Configuration may give pins to alternate functions; such pins read zero.
// - Group B bits 0,1,3,4 share one pull-up and one wake enable.
// - With external reset input selected, group B bit 3 loses pull-up and wake.
// - Direction registers are write-only, loaded only by the direction-load request.
// - Direction 1 leaves the pin floating; 0 drives it from its latch.
// - Timer settings in the option register may override group C bit 5 direction.
// - Output latches hold until rewritten; inputs are sampled, not latched.
// - Every pin has its own direction bit; group B bit 3's gates only its pull-up and wake.
// - Status bit 7 is set by a wake-up reset, cleared by others.
// - Bit set and clear read the whole port from pins and rewrite all latches.
// - Port writes land at cycle end; port reads sample at cycle start.
// - Option bits 7 and 6 are active-low enables, reset to one.
// - A pin set as output has no pull-up and no wake-up.
// - Timer clock source select at one makes group C bit 5 the timer input.
package dsbio_pkg;
    localparam int          DATA_W           = 8;
    localparam int          PORT_W           = 6;
    localparam logic [4:0]  ADDR_STATUS      = 5'h03;
    localparam logic [4:0]  ADDR_GRP_B       = 5'h06;
    localparam logic [4:0]  ADDR_GRP_C       = 5'h07;
    localparam logic [5:0]  DIR_RST          = 6'h3f;
    localparam logic [7:0]  OPT_RST          = 8'hff;
    localparam logic [5:0]  LATCH_RST        = 6'h00;
    localparam int          OPT_WAKE_DIS_BIT = 7;
    localparam int          OPT_PULL_DIS_BIT = 6;
    localparam int          OPT_TMR_SRC_BIT  = 5;
    localparam int          STAT_WAKE_BIT    = 7;
    localparam int          GRP_C_TMR_PIN    = 5;
    localparam logic [5:0]  GRP_B_SHARED     = 6'h1b;
    localparam logic [5:0]  GRP_B_RO         = 6'h08;
    localparam logic [5:0]  GRP_C_RO         = 6'h00;
    localparam logic [5:0]  GRP_C_TMR_MASK   = 6'h20;

    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } dsbio_phase_t;

    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_READ  = 3'h1,
        OP_WRITE = 3'h2,
        OP_BITOP = 3'h3,
        OP_DIRLD = 3'h4,
        OP_OPTLD = 3'h5
    } dsbio_op_t;
endpackage

// ### src/dsbio_grp_if.sv
// Carrier between the top and one six-bit pin group.
// Assumes the top drives control fields and the group returns pin views.
`timescale 1ns/1ps
`default_nettype none
interface dsbio_grp_if;
    logic [5:0] dir;
    logic [5:0] latch;
    logic [5:0] pin_in;
    logic [5:0] ro_mask;
    logic [5:0] alt_mask;
    logic [5:0] force_hiz;
    logic [5:0] oe;
    logic [5:0] out;
    logic [5:0] rd;
    modport owner (output dir, latch, pin_in, ro_mask, alt_mask, force_hiz,
                   input oe, out, rd);
    modport grp (input dir, latch, pin_in, ro_mask, alt_mask, force_hiz,
                 output oe, out, rd);
endinterface
`default_nettype wire

// ### src/dsbio_pin_group.sv
// Per-pin driver and read view of one six-bit group.
// Assumes the top registers every result before it reaches a pin.
`timescale 1ns/1ps
`default_nettype none
module dsbio_pin_group (
    dsbio_grp_if.grp g
);
    genvar i;
    generate
        for (i = 0; i < 6; i++) begin : g_bit
            // Input-only, overridden and alternate pins never drive
            assign g.oe[i]  = ~g.dir[i] & ~g.ro_mask[i] & ~g.force_hiz[i]
                              & ~g.alt_mask[i];
            assign g.out[i] = g.latch[i];
            // Pins read from the pad, not the latch
            assign g.rd[i]  = g.alt_mask[i] ? 1'b0 : g.pin_in[i];
        end
    endgenerate
endmodule
`default_nettype wire

// ### src/dsbio_top.sv
// Dual six-bit pin group block with direction, option and status wake flag.
// Assumes a core request held over the first clock of each instruction
// cycle, marked by cyc_start; pins are synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module dsbio_top (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst_n,
    // Core register requests
    input  wire logic [4:0]              reg_addr,
    input  wire logic                    reg_rd_en,
    input  wire logic                    reg_wr_en,
    input  wire logic [dsbio_pkg::DATA_W-1:0] reg_wr_data,
    input  wire logic                    bit_op_en,
    input  wire logic                    bit_op_set,
    input  wire logic [2:0]              bit_op_idx,
    input  wire logic                    direction_load,
    input  wire logic                    option_load,
    output logic [dsbio_pkg::DATA_W-1:0] reg_rd_data,
    output logic                         reg_rd_hit,
    output logic                         cyc_start,
    // Sleep and reset cause
    input  wire logic                    sleep_in,
    input  wire logic                    wake_cause_in,
    output logic                         wake_reset_req,
    // Configuration word
    input  wire logic [5:0]              cfg_alt_b,
    input  wire logic [5:0]              cfg_alt_c,
    input  wire logic                    cfg_ext_reset_en,
    // Group B pins
    input  wire logic [5:0]              pin_b_in,
    output logic [5:0]                   pin_b_out,
    output logic [5:0]                   pin_b_oe,
    output logic [5:0]                   pin_b_pullup_en,
    // Group C pins
    input  wire logic [5:0]              pin_c_in,
    output logic [5:0]                   pin_c_out,
    output logic [5:0]                   pin_c_oe,
    // Timer side
    output logic                         timer_external_clock_pin,
    output logic [5:0]                   timer_opt
);
    import dsbio_pkg::*;

    dsbio_phase_t      ph_r;
    dsbio_phase_t      ph_nxt;
    dsbio_op_t         op_r;
    dsbio_op_t         op_nxt;
    logic [4:0]        addr_r;
    logic [7:0]        data_r;
    logic [2:0]        bit_idx_r;
    logic              bit_set_r;
    logic [7:0]        snap_b_r;
    logic [7:0]        snap_c_r;
    logic [7:0]        rmw_val;
    logic [7:0]        wr_val;
    logic [5:0]        latch_b_r;
    logic [5:0]        latch_c_r;
    logic [5:0]        dir_b_r;
    logic [5:0]        dir_c_r;
    logic [7:0]        opt_r;
    logic [7:0]        rd_nxt;
    logic              rd_hit_nxt;
    logic [7:0]        rd_data_r;
    logic              rd_hit_r;
    logic              cyc_start_r;
    logic              wake_flag_r;
    logic              cause_done_r;
    logic [5:0]        last_b_r;
    logic [5:0]        watch_b;
    logic [5:0]        pull_b;
    logic              wake_req_r;
    logic [5:0]        b_out_r;
    logic [5:0]        b_oe_r;
    logic [5:0]        b_pull_r;
    logic [5:0]        c_out_r;
    logic [5:0]        c_oe_r;
    logic              tmr_pin_r;
    logic [5:0]        tmr_opt_r;
    logic              at_q1;
    logic              at_q4;
    logic [5:0]        ext_rst_mask;

    dsbio_grp_if gb ();
    dsbio_grp_if gc ();

    assign at_q1 = (ph_r == PH_Q1);
    assign at_q4 = (ph_r == PH_Q4);

    // Pin 3 of group B is taken by the external reset input when selected
    assign ext_rst_mask = cfg_ext_reset_en ? GRP_B_RO : 6'h00;

    assign gb.dir       = dir_b_r;
    assign gb.latch     = latch_b_r;
    assign gb.pin_in    = pin_b_in;
    assign gb.ro_mask   = GRP_B_RO;
    assign gb.alt_mask  = cfg_alt_b | ext_rst_mask;
    assign gb.force_hiz = 6'h00;

    assign gc.dir       = dir_c_r;
    assign gc.latch     = latch_c_r;
    assign gc.pin_in    = pin_c_in;
    assign gc.ro_mask   = GRP_C_RO;
    assign gc.alt_mask  = cfg_alt_c;
    assign gc.force_hiz = opt_r[OPT_TMR_SRC_BIT] ? GRP_C_TMR_MASK : 6'h00;

    dsbio_pin_group u_grp_b (
        .g (gb.grp)
    );

    dsbio_pin_group u_grp_c (
        .g (gc.grp)
    );

    // Four-phase instruction cycle
    // Reset parks on Q1, so the first edge after release takes a request
    always_comb begin
        case (ph_r)
            PH_Q1:   ph_nxt = PH_Q2;
            PH_Q2:   ph_nxt = PH_Q3;
            PH_Q3:   ph_nxt = PH_Q4;
            PH_Q4:   ph_nxt = PH_Q1;
            default: ph_nxt = PH_Q1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ph_r <= PH_Q1;
        end else begin
            ph_r <= ph_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cyc_start_r <= 1'b0;
        end else begin
            cyc_start_r <= (ph_nxt == PH_Q1);
        end
    end

    // One request per cycle; loads beat bit ops, bit ops beat plain accesses
    always_comb begin
        if (direction_load) begin
            op_nxt = OP_DIRLD;
        end else if (option_load) begin
            op_nxt = OP_OPTLD;
        end else if (bit_op_en) begin
            op_nxt = OP_BITOP;
        end else if (reg_wr_en) begin
            op_nxt = OP_WRITE;
        end else if (reg_rd_en) begin
            op_nxt = OP_READ;
        end else begin
            op_nxt = OP_NONE;
        end
    end

    // Request fields captured once; later edges of the cycle ignore the bus
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            op_r      <= OP_NONE;
            addr_r    <= 5'h00;
            data_r    <= 8'h00;
            bit_idx_r <= 3'h0;
            bit_set_r <= 1'b0;
        end else if (at_q1) begin
            op_r      <= op_nxt;
            addr_r    <= reg_addr;
            data_r    <= reg_wr_data;
            bit_idx_r <= bit_op_idx;
            bit_set_r <= bit_op_set;
        end else if (at_q4) begin
            op_r      <= OP_NONE;
        end
    end

    // Pin levels taken at the start of the cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            snap_b_r <= 8'h00;
            snap_c_r <= 8'h00;
        end else if (at_q1) begin
            snap_b_r <= {2'b00, gb.rd};
            snap_c_r <= {2'b00, gc.rd};
        end
    end

    // Read-modify-write works on the pin snapshot, so inputs leak into latches
    always_comb begin
        rmw_val = (addr_r == ADDR_GRP_C) ? snap_c_r : snap_b_r;
        rmw_val[bit_idx_r] = bit_set_r;
        wr_val = (op_r == OP_BITOP) ? rmw_val : data_r;
    end

    // Latches change only at the end of a writing cycle
    // Writes to the status address fall through and change nothing
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            latch_b_r <= LATCH_RST;
            latch_c_r <= LATCH_RST;
        end else if (at_q4 && (op_r == OP_WRITE || op_r == OP_BITOP)) begin
            if (addr_r == ADDR_GRP_B) begin
                latch_b_r <= wr_val[5:0];
            end
            if (addr_r == ADDR_GRP_C) begin
                latch_c_r <= wr_val[5:0];
            end
        end
    end

    // No read path exists, so software must keep its own copy
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_b_r <= DIR_RST;
            dir_c_r <= DIR_RST;
        end else if (at_q4 && op_r == OP_DIRLD) begin
            if (addr_r == ADDR_GRP_B) begin
                dir_b_r <= data_r[5:0];
            end
            if (addr_r == ADDR_GRP_C) begin
                dir_c_r <= data_r[5:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            opt_r <= OPT_RST;
        end else if (at_q4 && op_r == OP_OPTLD) begin
            opt_r <= data_r;
        end
    end

    // Read answer; direction and option registers have no read path
    always_comb begin
        rd_nxt     = 8'h00;
        rd_hit_nxt = 1'b1;
        case (reg_addr)
            ADDR_GRP_B:  rd_nxt = {2'b00, gb.rd};
            ADDR_GRP_C:  rd_nxt = {2'b00, gc.rd};
            ADDR_STATUS: rd_nxt[STAT_WAKE_BIT] = wake_flag_r;
            default:     rd_hit_nxt = 1'b0;
        endcase
    end

    // Answer stands until the next request edge, so a slow core still sees it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= 8'h00;
            rd_hit_r  <= 1'b0;
        end else if (at_q1) begin
            if (op_nxt == OP_READ || op_nxt == OP_BITOP) begin
                rd_data_r <= rd_nxt;
                rd_hit_r  <= rd_hit_nxt;
            end else begin
                rd_data_r <= 8'h00;
                rd_hit_r  <= 1'b0;
            end
        end
    end

    // Reset cause is caught once after release; async reset only clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_flag_r  <= 1'b0;
            cause_done_r <= 1'b0;
        end else if (!cause_done_r) begin
            wake_flag_r  <= wake_cause_in;
            cause_done_r <= 1'b1;
        end
    end

    // Shared enables gated per pin by direction and reset-pin use
    always_comb begin
        watch_b = GRP_B_SHARED & dir_b_r & ~cfg_alt_b & ~ext_rst_mask;
        pull_b  = opt_r[OPT_PULL_DIS_BIT] ? 6'h00 : watch_b;
    end

    // Reference for change detection is the value last read from group B
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_b_r <= 6'h00;
        end else if (at_q1 && reg_addr == ADDR_GRP_B
                     && (op_nxt == OP_READ || op_nxt == OP_BITOP)) begin
            last_b_r <= gb.rd;
        end
    end

    // Request stays up until the system resets the block
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_req_r <= 1'b0;
        end else if (sleep_in && !opt_r[OPT_WAKE_DIS_BIT]
                     && ((pin_b_in & watch_b) != (last_b_r & watch_b))) begin
            wake_req_r <= 1'b1;
        end
    end

    // Pins see only registered values
    // Costs a cycle of latency, but no pin glitches while requests decode
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            b_out_r  <= 6'h00;
            b_oe_r   <= 6'h00;
            b_pull_r <= 6'h00;
            c_out_r  <= 6'h00;
            c_oe_r   <= 6'h00;
        end else begin
            b_out_r  <= gb.out;
            b_oe_r   <= gb.oe;
            b_pull_r <= pull_b;
            c_out_r  <= gc.out;
            c_oe_r   <= gc.oe;
        end
    end

    // Timer input gated off while unused, so a floating pin sends no edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tmr_pin_r <= 1'b0;
            tmr_opt_r <= OPT_RST[5:0];
        end else begin
            tmr_pin_r <= opt_r[OPT_TMR_SRC_BIT] & pin_c_in[GRP_C_TMR_PIN];
            tmr_opt_r <= opt_r[5:0];
        end
    end

    assign reg_rd_data              = rd_data_r;
    assign reg_rd_hit               = rd_hit_r;
    assign cyc_start                = cyc_start_r;
    assign wake_reset_req           = wake_req_r;
    assign pin_b_out                = b_out_r;
    assign pin_b_oe                 = b_oe_r;
    assign pin_b_pullup_en          = b_pull_r;
    assign pin_c_out                = c_out_r;
    assign pin_c_oe                 = c_oe_r;
    assign timer_external_clock_pin = tmr_pin_r;
    assign timer_opt                = tmr_opt_r;
endmodule
`default_nettype wire

// ### verification/dsbio_top_sva.sv
// Checker for the dual six-bit pin group block, watching top ports only.
// Assumes requests are taken at the edge that ends a cyc_start clock.
`timescale 1ns/1ps
`default_nettype none
module dsbio_top_sva
    import dsbio_pkg::*;
(
    // Clock and reset
    input wire logic                          clk_sys,
    input wire logic                          rst_n,
    // Core requests and answers
    input wire logic [4:0]                    reg_addr,
    input wire logic                          reg_rd_en,
    input wire logic                          reg_wr_en,
    input wire logic [dsbio_pkg::DATA_W-1:0]  reg_wr_data,
    input wire logic                          bit_op_en,
    input wire logic                          direction_load,
    input wire logic                          option_load,
    input wire logic [dsbio_pkg::DATA_W-1:0]  reg_rd_data,
    input wire logic                          reg_rd_hit,
    input wire logic                          cyc_start,
    input wire logic                          wake_reset_req,
    // Configuration and pins
    input wire logic [5:0]                    cfg_alt_b,
    input wire logic [5:0]                    cfg_alt_c,
    input wire logic                          cfg_ext_reset_en,
    input wire logic [5:0]                    pin_b_in,
    input wire logic [5:0]                    pin_b_out,
    input wire logic [5:0]                    pin_b_oe,
    input wire logic [5:0]                    pin_b_pullup_en,
    input wire logic [5:0]                    pin_c_oe,
    input wire logic [5:0]                    timer_opt
);
    logic       solo;
    logic [5:0] wr6;
    // Higher-priority requests would swallow a read or write
    assign solo = cyc_start & ~bit_op_en & ~direction_load & ~option_load;
    assign wr6  = reg_wr_data[5:0];

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_rd_pins;
        solo && !reg_wr_en && reg_rd_en && reg_addr == ADDR_GRP_B && cfg_alt_b == 6'h00
        |=> reg_rd_hit && reg_rd_data == {2'b00, $past(pin_b_in)
                                          & ~($past(cfg_ext_reset_en) ? GRP_B_RO : 6'h00)};
    endproperty
    a_rd_pins: assert property (p_rd_pins) else $error("port read differs from pins");
    property p_rd_top;
        reg_rd_hit |-> reg_rd_data[7:6] == 2'b00;
    endproperty
    a_rd_top: assert property (p_rd_top) else $error("upper read bits not zero");
    property p_status;
        solo && !reg_wr_en && reg_rd_en && reg_addr == ADDR_STATUS
        |=> reg_rd_hit && reg_rd_data[6:0] == 7'h00;
    endproperty
    a_status: assert property (p_status) else $error("status read has stray bits");
    property p_wr_latch;
        solo && reg_wr_en && reg_addr == ADDR_GRP_B |-> ##5 pin_b_out == $past(wr6, 5);
    endproperty
    a_wr_latch: assert property (p_wr_latch) else $error("write did not reach latch");
    property p_b3_in;
        pin_b_oe[3] == 1'b0;
    endproperty
    a_b3_in: assert property (p_b3_in) else $error("input-only pin driven");
    property p_rst_dir;
        $rose(rst_n) |-> (pin_b_oe == 6'h00 && pin_c_oe == 6'h00) [*4];
    endproperty
    a_rst_dir: assert property (p_rst_dir) else $error("driver on after reset");
    property p_alt_off;
        ((pin_b_oe & $past(cfg_alt_b)) | (pin_c_oe & $past(cfg_alt_c))) == 6'h00;
    endproperty
    a_alt_off: assert property (p_alt_off) else $error("alternate pin driven");
    property p_c5_tmr;
        timer_opt[5] |-> !pin_c_oe[5];
    endproperty
    a_c5_tmr: assert property (p_c5_tmr) else $error("timer input pin driven");
    property p_pull_grp;
        (pin_b_pullup_en & ~GRP_B_SHARED) == 6'h00 && (pin_b_pullup_en & pin_b_oe) == 6'h00;
    endproperty
    a_pull_grp: assert property (p_pull_grp) else $error("pull-up on wrong pin");
    property p_pull_rst;
        cfg_ext_reset_en && $past(cfg_ext_reset_en) |-> !pin_b_pullup_en[3];
    endproperty
    a_pull_rst: assert property (p_pull_rst) else $error("pull-up on reset input");
    property p_wake_hold;
        wake_reset_req |=> wake_reset_req;
    endproperty
    a_wake_hold: assert property (p_wake_hold) else $error("wake request dropped");

    c_read: cover property (solo && reg_rd_en && reg_addr == ADDR_GRP_B);
    c_write: cover property (solo && reg_wr_en && reg_addr == ADDR_GRP_B);
    c_bitop: cover property (cyc_start && bit_op_en);
    c_wake: cover property ($rose(wake_reset_req));
endmodule
bind dsbio_top dsbio_top_sva u_sva (.*);
`default_nettype wire

// ### verification/dsbio_pin_model.sv
// External loads on both pin groups: bench drivers, group B pull-ups, floating lines.
// Assumes the bench names which pins it drives and at what level.
`timescale 1ns/1ps
`default_nettype none
module dsbio_pin_model (
    // Clock
    input  wire logic       clk_sys,
    // Block side
    input  wire logic [5:0] b_out,
    input  wire logic [5:0] b_oe,
    input  wire logic [5:0] b_pull,
    input  wire logic [5:0] c_out,
    input  wire logic [5:0] c_oe,
    // Bench side
    input  wire logic [5:0] ext_b,
    input  wire logic [5:0] ext_b_en,
    input  wire logic [5:0] ext_c,
    input  wire logic [5:0] ext_c_en,
    // Pin levels
    output logic [5:0]      pin_b_lvl,
    output logic [5:0]      pin_c_lvl
);
    logic [5:0] float_r = 6'h15;
    // Undriven lines wander so a stale level never passes for a match
    always @(posedge clk_sys) begin
        float_r <= ~float_r;
    end
    // A strong outside drive wins over the block, like a shorted load
    assign pin_b_lvl = (ext_b_en & ext_b) | (~ext_b_en & b_oe & b_out)
                     | (~ext_b_en & ~b_oe & (b_pull | float_r));
    assign pin_c_lvl = (ext_c_en & ext_c) | (~ext_c_en & c_oe & c_out)
                     | (~ext_c_en & ~c_oe & float_r);
endmodule
`default_nettype wire

// ### verification/dsbio_top_bench.sv
// Self-checking bench for the dual six-bit pin group block.
// Assumes the pin model stands on the pins and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module dsbio_top_bench;
    import dsbio_pkg::*;
    logic       clk_sys, rst_n, reg_rd_en, reg_wr_en, bit_op_en, bit_op_set;
    logic       direction_load, option_load, reg_rd_hit, cyc_start, sleep_in;
    logic       wake_cause_in, wake_reset_req, cfg_ext_reset_en, timer_external_clock_pin;
    logic [4:0] reg_addr;
    logic [2:0] bit_op_idx;
    logic [7:0] reg_wr_data, reg_rd_data;
    logic [5:0] cfg_alt_b, cfg_alt_c, pin_b_in, pin_b_out, pin_b_oe, pin_b_pullup_en;
    logic [5:0] pin_c_in, pin_c_out, pin_c_oe, timer_opt, ext_b, ext_b_en, ext_c, ext_c_en;
    int         fail_count, checked, cycles;

    dsbio_top dut (.clk_sys, .rst_n, .reg_addr, .reg_rd_en, .reg_wr_en, .reg_wr_data,
        .bit_op_en, .bit_op_set, .bit_op_idx, .direction_load, .option_load, .reg_rd_data,
        .reg_rd_hit, .cyc_start, .sleep_in, .wake_cause_in, .wake_reset_req, .cfg_alt_b,
        .cfg_alt_c, .cfg_ext_reset_en, .pin_b_in, .pin_b_out, .pin_b_oe, .pin_b_pullup_en,
        .pin_c_in, .pin_c_out, .pin_c_oe, .timer_external_clock_pin, .timer_opt);
    dsbio_pin_model u_pins (.clk_sys, .b_out(pin_b_out), .b_oe(pin_b_oe),
        .b_pull(pin_b_pullup_en), .c_out(pin_c_out), .c_oe(pin_c_oe), .ext_b, .ext_b_en,
        .ext_c, .ext_c_en, .pin_b_lvl(pin_b_in), .pin_c_lvl(pin_c_in));

    always #10 clk_sys = ~clk_sys;

    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reset_dut(input logic cause);
        rst_n = 1'b0;
        wake_cause_in = cause;
        tick(8);
        rst_n = 1'b1;
        tick(1);
    endtask

    // Bit ops carry set in data bit 3 and the index in bits 2:0
    task automatic issue(input dsbio_op_t op, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (cyc_start !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        reg_addr = a;
        reg_wr_data = d;
        {bit_op_set, bit_op_idx} = d[3:0];
        reg_rd_en = (op == OP_READ);
        reg_wr_en = (op == OP_WRITE);
        bit_op_en = (op == OP_BITOP);
        direction_load = (op == OP_DIRLD);
        option_load = (op == OP_OPTLD);
        tick(1);
        {reg_rd_en, reg_wr_en, bit_op_en, direction_load, option_load} = '0;
    endtask

    task automatic read_chk(input string what, input logic [4:0] a, input logic [7:0] exp);
        issue(OP_READ, a, 8'h00);
        chk(what, exp, reg_rd_data);
    endtask

    initial begin
        clk_sys = 1'b0;
        {reg_rd_en, reg_wr_en, bit_op_en, bit_op_set, direction_load, option_load} = '0;
        {sleep_in, cfg_ext_reset_en, reg_addr, bit_op_idx, reg_wr_data} = '0;
        {cfg_alt_b, cfg_alt_c} = '0;
        {ext_b, ext_b_en, ext_c, ext_c_en} = {6'h2a, 6'h3f, 6'h15, 6'h3f};
        reset_dut(1'b0);
        chk("b drivers", 8'h00, {2'b00, pin_b_oe});
        chk("c drivers", 8'h00, {2'b00, pin_c_oe});
        chk("pull-ups", 8'h00, {2'b00, pin_b_pullup_en});
        chk("timer option", 8'h3f, {2'b00, timer_opt});
        read_chk("b pins", ADDR_GRP_B, 8'h2a);
        read_chk("c pins", ADDR_GRP_C, 8'h15);
        read_chk("status", ADDR_STATUS, 8'h00);
        read_chk("unmapped", 5'h05, 8'h00);
        chk("unmapped hit", 8'h00, {7'h00, reg_rd_hit});
        // Bit 0 held low from outside while the block drives it high
        {ext_b, ext_b_en} = {6'h00, 6'h09};
        issue(OP_WRITE, ADDR_GRP_B, 8'hff);
        issue(OP_DIRLD, ADDR_GRP_B, 8'h00);
        tick(5);
        chk("b latch", 8'h3f, {2'b00, pin_b_out});
        chk("b drivers", 8'h37, {2'b00, pin_b_oe});
        read_chk("b contended", ADDR_GRP_B, 8'h36);
        issue(OP_BITOP, ADDR_GRP_B, 8'h05);
        tick(5);
        chk("b after clear", 8'h16, {2'b00, pin_b_out});
        issue(OP_BITOP, ADDR_GRP_B, 8'h0d);
        tick(5);
        chk("b after set", 8'h36, {2'b00, pin_b_out});
        {ext_c, ext_c_en} = {6'h24, 6'h25};
        issue(OP_DIRLD, ADDR_GRP_C, 8'h05);
        issue(OP_WRITE, ADDR_GRP_C, 8'h2a);
        tick(5);
        chk("c drivers", 8'h1a, {2'b00, pin_c_oe});
        chk("c latch", 8'h2a, {2'b00, pin_c_out});
        chk("timer pin", 8'h01, {7'h00, timer_external_clock_pin});
        read_chk("c mixed", ADDR_GRP_C, 8'h2e);
        issue(OP_OPTLD, 5'h00, 8'h1f);
        tick(5);
        chk("c drivers", 8'h3a, {2'b00, pin_c_oe});
        chk("timer option", 8'h1f, {2'b00, timer_opt});
        chk("pull on outputs", 8'h00, {2'b00, pin_b_pullup_en});
        issue(OP_DIRLD, ADDR_GRP_B, 8'h3f);
        tick(5);
        chk("pull-ups", 8'h1b, {2'b00, pin_b_pullup_en});
        cfg_ext_reset_en = 1'b1;
        tick(3);
        chk("pull-ups", 8'h13, {2'b00, pin_b_pullup_en});
        {ext_b, ext_b_en, cfg_alt_b} = {6'h3f, 6'h3f, 6'h02};
        tick(2);
        // Reset input selected, so bit 3 reads zero as well
        read_chk("b alternate", ADDR_GRP_B, 8'h35);
        cfg_alt_b = 6'h00;
        tick(2);
        read_chk("b pins", ADDR_GRP_B, 8'h37);
        // Asleep: reset pin changes are ignored, a watched pin wakes
        sleep_in = 1'b1;
        ext_b = 6'h37;
        tick(4);
        chk("wake on reset pin", 8'h00, {7'h00, wake_reset_req});
        ext_b = 6'h27;
        tick(3);
        chk("wake request", 8'h01, {7'h00, wake_reset_req});
        sleep_in = 1'b0;
        reset_dut(1'b1);
        chk("wake cleared", 8'h00, {7'h00, wake_reset_req});
        read_chk("status", ADDR_STATUS, 8'h80);
        reset_dut(1'b0);
        read_chk("status", ADDR_STATUS, 8'h00);
        wrap_up();
    end
endmodule
`default_nettype wire
